//--- core/tmxz_top.v
`timescale 1ns/1ps
`default_nettype none
`include "tmxz_consts.vh"
module tmxz_top (
    input wire clk_in,
    input wire rst_n_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    input wire meas_in,
    output reg [31:0] hrdata_out,
    output reg hreadyout_out,
    output reg hresp_out,
    output reg pulse_out,
    output reg irq_out
);
    // Bus state
    reg wr_pend;
    reg [7:0] wr_addr;
    reg [31:0] rd_data;

    // Timer A state
    reg tmr_a_mode_lo;
    reg tmr_a_mode_hi;
    reg tmr_a_mode_ext;
    reg tmr_a_run_req;
    reg tmr_a_run;
    reg tmr_a_edge_flag;
    reg tmr_a_underflow_flag;
    reg [7:0] a_pre_rld;
    reg [7:0] a_pre_cnt;
    reg [7:0] a_cnt_rld;
    reg [7:0] a_cnt;
    reg meas_q;

    // Timer B state
    reg tmr_b_mode_lo;
    reg tmr_b_mode_hi;
    reg tmr_b_run_req;
    reg tmr_b_run;
    reg tmr_b_oneshot_start;
    reg tmr_b_output_ctrl;
    reg [7:0] b_pre_rld;
    reg [7:0] b_pre_cnt;
    reg [7:0] b_sec;
    reg [7:0] b_pri;
    reg [7:0] b_cnt;
    reg b_phase;
    reg b_tgl;

    // Shared registers
    reg [1:0] count_source_select;
    reg [1:0] count_source_select_b;
    reg [2:0] irq_stat;
    reg [2:0] irq_mask;

    // Address phase accepted
    wire addr_ok = hsel_in & htrans_in[1] & hready_in;

    // Write strobes in the data phase
    wire wr_a_mode = wr_pend & (wr_addr == `TMXZ_OFF_A_MODE);
    wire wr_a_pre = wr_pend & (wr_addr == `TMXZ_OFF_A_PRE);
    wire wr_a_cnt = wr_pend & (wr_addr == `TMXZ_OFF_A_CNT);
    wire wr_src = wr_pend & (wr_addr == `TMXZ_OFF_SRC);
    wire wr_b_mode = wr_pend & (wr_addr == `TMXZ_OFF_B_MODE);
    wire wr_b_pre = wr_pend & (wr_addr == `TMXZ_OFF_B_PRE);
    wire wr_b_sec = wr_pend & (wr_addr == `TMXZ_OFF_B_SEC);
    wire wr_b_pri = wr_pend & (wr_addr == `TMXZ_OFF_B_PRI);
    wire wr_b_os = wr_pend & (wr_addr == `TMXZ_OFF_B_OS);
    wire wr_stat = wr_pend & (wr_addr == `TMXZ_OFF_IRQ_STAT);
    wire wr_mask = wr_pend & (wr_addr == `TMXZ_OFF_IRQ_MASK);

    // Count-source ticks, one per timer
    wire [3:0] src_sel = {count_source_select_b, count_source_select};
    wire [1:0] src_tick;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_src
            tmxz_src u_src (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .sel_in(src_sel[2*gi+1:2*gi]),
                .tick_out(src_tick[gi])
            );
        end
    endgenerate

    // Timer A decode
    wire [1:0] a_mode = {tmr_a_mode_hi, tmr_a_mode_lo};
    wire a_meas = (a_mode == `TMXZ_A_MODE_MEAS);
    wire a_cnt_en = src_tick[0] & tmr_a_run_req;
    wire a_pre_unf = a_cnt_en & (a_pre_cnt == 8'h00);
    wire a_unf = a_pre_unf & (a_cnt == 8'h00);
    wire a_edge = a_meas & tmr_a_run & meas_in & ~meas_q;

    // Timer B decode
    wire [1:0] b_mode = {tmr_b_mode_hi, tmr_b_mode_lo};
    wire b_os = b_mode[1];
    wire b_wait = (b_mode == `TMXZ_B_MODE_WAIT);
    wire b_cnt_en = src_tick[1] & tmr_b_run_req & (~b_os | tmr_b_oneshot_start);
    wire b_pre_unf = b_cnt_en & (b_pre_cnt == 8'h00);
    wire b_unf = b_pre_unf & (b_cnt == 8'h00);
    wire b_prim_done = b_unf & ~b_phase;
    wire b_sw_stop = b_os & ((wr_b_mode & ~hwdata_in[`TMXZ_B_RUN] & tmr_b_run_req)
        | (wr_b_os & ~hwdata_in[`TMXZ_OS_START] & tmr_b_oneshot_start));
    wire b_os_go = b_os & wr_b_os & hwdata_in[`TMXZ_OS_START] & ~tmr_b_oneshot_start;

    // Interrupt events and software clears
    wire [2:0] irq_set = {b_unf, a_edge, a_unf};
    wire [2:0] irq_clr = wr_stat ? hwdata_in[2:0] : 3'h0;

    // Read multiplexer, sampled in the address phase
    always @* begin
        rd_data = 32'h00000000;
        case (haddr_in[7:0])
            `TMXZ_OFF_A_MODE: begin
                rd_data[`TMXZ_A_MLO] = tmr_a_mode_lo;
                rd_data[`TMXZ_A_MHI] = tmr_a_mode_hi;
                rd_data[`TMXZ_A_MEXT] = tmr_a_mode_ext;
                rd_data[`TMXZ_A_EDGE] = tmr_a_edge_flag;
                rd_data[`TMXZ_A_RUN] = tmr_a_run;
                rd_data[`TMXZ_A_UNF] = tmr_a_underflow_flag;
            end
            `TMXZ_OFF_A_PRE: rd_data[7:0] = a_pre_cnt;
            `TMXZ_OFF_A_CNT: rd_data[7:0] = a_cnt;
            `TMXZ_OFF_SRC: begin
                rd_data[`TMXZ_SRC_A_LSB+1:`TMXZ_SRC_A_LSB] = count_source_select;
                rd_data[`TMXZ_SRC_B_LSB+1:`TMXZ_SRC_B_LSB] = count_source_select_b;
            end
            `TMXZ_OFF_B_MODE: begin
                rd_data[`TMXZ_B_MLO] = tmr_b_mode_lo;
                rd_data[`TMXZ_B_MHI] = tmr_b_mode_hi;
                rd_data[`TMXZ_B_RUN] = tmr_b_run;
            end
            `TMXZ_OFF_B_PRE: rd_data[7:0] = b_pre_cnt;
            `TMXZ_OFF_B_SEC: rd_data[7:0] = b_sec;
            `TMXZ_OFF_B_PRI: rd_data[7:0] = b_cnt;
            `TMXZ_OFF_B_OS: begin
                rd_data[`TMXZ_OS_START] = tmr_b_oneshot_start;
                rd_data[`TMXZ_OS_OUTCTL] = tmr_b_output_ctrl;
            end
            `TMXZ_OFF_IRQ_STAT: rd_data[2:0] = irq_stat;
            `TMXZ_OFF_IRQ_MASK: rd_data[2:0] = irq_mask;
            default: rd_data = 32'h00000000;
        endcase
    end

    // Bus slave: zero wait states, always OKAY
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata_out <= 32'h00000000;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            wr_pend <= addr_ok & hwrite_in;
            if (addr_ok) begin
                wr_addr <= haddr_in[7:0];
            end
            if (addr_ok & ~hwrite_in) begin
                hrdata_out <= rd_data;
            end
        end
    end

    // Count source selects
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_source_select <= `TMXZ_RST_SRC;
            count_source_select_b <= `TMXZ_RST_SRC;
        end else if (wr_src) begin
            count_source_select <= hwdata_in[`TMXZ_SRC_A_LSB+1:`TMXZ_SRC_A_LSB];
            count_source_select_b <= hwdata_in[`TMXZ_SRC_B_LSB+1:`TMXZ_SRC_B_LSB];
        end
    end

    // Timer A control bits and run synchronisation
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            tmr_a_mode_lo <= 1'b0;
            tmr_a_mode_hi <= 1'b0;
            tmr_a_mode_ext <= 1'b0;
            tmr_a_run_req <= 1'b0;
            tmr_a_run <= 1'b0;
            meas_q <= 1'b0;
        end else begin
            meas_q <= meas_in;
            if (wr_a_mode) begin
                tmr_a_mode_lo <= hwdata_in[`TMXZ_A_MLO];
                tmr_a_mode_hi <= hwdata_in[`TMXZ_A_MHI];
                tmr_a_mode_ext <= hwdata_in[`TMXZ_A_MEXT];
                tmr_a_run_req <= hwdata_in[`TMXZ_A_RUN];
            end
            if (src_tick[0]) begin
                tmr_a_run <= tmr_a_run_req;
            end
        end
    end

    // Timer A measurement flags, event wins over clear
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            tmr_a_edge_flag <= 1'b0;
            tmr_a_underflow_flag <= 1'b0;
        end else begin
            if (a_edge) begin
                tmr_a_edge_flag <= 1'b1;
            end else if (wr_a_mode & a_meas & ~hwdata_in[`TMXZ_A_EDGE]) begin
                tmr_a_edge_flag <= 1'b0;
            end
            if (a_meas & a_unf) begin
                tmr_a_underflow_flag <= 1'b1;
            end else if (wr_a_mode & a_meas & ~hwdata_in[`TMXZ_A_UNF]) begin
                tmr_a_underflow_flag <= 1'b0;
            end
        end
    end

    // Timer A prescaler and counter
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            a_pre_rld <= `TMXZ_RST_RLD;
            a_pre_cnt <= `TMXZ_RST_RLD;
            a_cnt_rld <= `TMXZ_RST_RLD;
            a_cnt <= `TMXZ_RST_RLD;
        end else begin
            if (wr_a_pre) begin
                a_pre_rld <= hwdata_in[7:0];
                a_pre_cnt <= hwdata_in[7:0];
            end else if (a_pre_unf) begin
                a_pre_cnt <= a_pre_rld;
            end else if (a_cnt_en) begin
                a_pre_cnt <= a_pre_cnt - 8'h01;
            end
            if (wr_a_cnt) begin
                a_cnt_rld <= hwdata_in[7:0];
                a_cnt <= hwdata_in[7:0];
            end else if (a_edge) begin
                a_cnt <= a_cnt_rld;
            end else if (a_unf) begin
                a_cnt <= a_cnt_rld;
            end else if (a_pre_unf) begin
                a_cnt <= a_cnt - 8'h01;
            end
        end
    end

    // Timer B control bits and run synchronisation
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            tmr_b_mode_lo <= 1'b0;
            tmr_b_mode_hi <= 1'b0;
            tmr_b_run_req <= 1'b0;
            tmr_b_run <= 1'b0;
            tmr_b_oneshot_start <= 1'b0;
            tmr_b_output_ctrl <= 1'b0;
        end else begin
            if (wr_b_mode) begin
                tmr_b_mode_lo <= hwdata_in[`TMXZ_B_MLO];
                tmr_b_mode_hi <= hwdata_in[`TMXZ_B_MHI];
                tmr_b_run_req <= hwdata_in[`TMXZ_B_RUN];
            end
            if (src_tick[1]) begin
                tmr_b_run <= tmr_b_run_req;
            end
            if (wr_b_os) begin
                tmr_b_oneshot_start <= hwdata_in[`TMXZ_OS_START];
                tmr_b_output_ctrl <= hwdata_in[`TMXZ_OS_OUTCTL];
            end else if (b_os & b_prim_done) begin
                tmr_b_oneshot_start <= 1'b0;
            end
        end
    end

    // Timer B prescaler, counter and one-shot phase
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            b_pre_rld <= `TMXZ_RST_RLD;
            b_pre_cnt <= `TMXZ_RST_RLD;
            b_sec <= `TMXZ_RST_RLD;
            b_pri <= `TMXZ_RST_RLD;
            b_cnt <= `TMXZ_RST_RLD;
            b_phase <= 1'b0;
            b_tgl <= 1'b0;
        end else begin
            if (wr_b_sec) begin
                b_sec <= hwdata_in[7:0];
            end
            if (wr_b_pre) begin
                b_pre_rld <= hwdata_in[7:0];
                b_pre_cnt <= hwdata_in[7:0];
            end else if (b_sw_stop | b_os_go | b_pre_unf) begin
                b_pre_cnt <= b_pre_rld;
            end else if (b_cnt_en) begin
                b_pre_cnt <= b_pre_cnt - 8'h01;
            end
            if (wr_b_pri) begin
                b_pri <= hwdata_in[7:0];
                b_cnt <= hwdata_in[7:0];
            end else if (b_sw_stop) begin
                b_cnt <= b_pri;
                b_phase <= 1'b0;
            end else if (b_os_go) begin
                b_cnt <= b_wait ? b_sec : b_pri;
                b_phase <= b_wait;
            end else if (b_unf) begin
                b_cnt <= b_pri;
                b_phase <= 1'b0;
            end else if (b_pre_unf) begin
                b_cnt <= b_cnt - 8'h01;
            end
            if (b_unf & ~b_os) begin
                b_tgl <= ~b_tgl;
            end
        end
    end

    // Timer B output pin, polarity from output control
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= (b_os ? (tmr_b_oneshot_start & ~b_phase) : b_tgl)
                ^ tmr_b_output_ctrl;
        end
    end

    // Sticky status, write one to clear, set wins
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_stat <= 3'h0;
            irq_mask <= `TMXZ_RST_MASK;
            irq_out <= 1'b0;
        end else begin
            irq_stat <= irq_set | (irq_stat & ~irq_clr);
            if (wr_mask) begin
                irq_mask <= hwdata_in[2:0];
            end
            irq_out <= |(irq_stat & irq_mask);
        end
    end
endmodule // tmxz_top
`default_nettype wire

//--- core/tmxz_consts.vh
`ifndef TMXZ_CONSTS_VH
`define TMXZ_CONSTS_VH

// Register offsets
`define TMXZ_OFF_A_MODE 8'h00
`define TMXZ_OFF_A_PRE 8'h04
`define TMXZ_OFF_A_CNT 8'h08
`define TMXZ_OFF_SRC 8'h0c
`define TMXZ_OFF_B_MODE 8'h10
`define TMXZ_OFF_B_PRE 8'h14
`define TMXZ_OFF_B_SEC 8'h18
`define TMXZ_OFF_B_PRI 8'h1c
`define TMXZ_OFF_B_OS 8'h20
`define TMXZ_OFF_IRQ_STAT 8'h24
`define TMXZ_OFF_IRQ_MASK 8'h28

// Timer A mode register fields
`define TMXZ_A_MLO 0
`define TMXZ_A_MHI 1
`define TMXZ_A_MEXT 2
`define TMXZ_A_EDGE 3
`define TMXZ_A_RUN 4
`define TMXZ_A_UNF 5
// Timer B mode register fields
`define TMXZ_B_MLO 4
`define TMXZ_B_MHI 5
`define TMXZ_B_RUN 7
// One-shot control fields
`define TMXZ_OS_START 0
`define TMXZ_OS_OUTCTL 1
// Source select field positions
`define TMXZ_SRC_A_LSB 0
`define TMXZ_SRC_B_LSB 4
// Interrupt status bits
`define TMXZ_IRQ_A_UNF 0
`define TMXZ_IRQ_A_EDGE 1
`define TMXZ_IRQ_B_UNF 2

// Modes
`define TMXZ_A_MODE_MEAS 2'h1
`define TMXZ_B_MODE_WAIT 2'h3

// Reset values
`define TMXZ_RST_RLD 8'hff
`define TMXZ_RST_SRC 2'h0
`define TMXZ_RST_MASK 3'h0

// Count source divider masks: divide by 1, 2, 8, 32
`define TMXZ_DIV1_MASK 5'h00
`define TMXZ_DIV2_MASK 5'h01
`define TMXZ_DIV8_MASK 5'h07
`define TMXZ_DIV32_MASK 5'h1f
`endif

//--- core/tmxz_src.v
`timescale 1ns/1ps
`default_nettype none
`include "tmxz_consts.vh"
module tmxz_src (
    input wire clk_in,
    input wire rst_n_in,
    input wire [1:0] sel_in,
    output reg tick_out
);
    reg [4:0] div;
    reg [4:0] mask;

    // Divider ratio from the source select
    always @* begin
        case (sel_in)
            2'h0: mask = `TMXZ_DIV1_MASK;
            2'h1: mask = `TMXZ_DIV2_MASK;
            2'h2: mask = `TMXZ_DIV8_MASK;
            default: mask = `TMXZ_DIV32_MASK;
        endcase
    end

    // Free divider, one-cycle count-source tick
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            div <= 5'h00;
            tick_out <= 1'b0;
        end else begin
            div <= div + 5'h01;
            tick_out <= ((div & mask) == mask);
        end
    end
endmodule // tmxz_src
`default_nettype wire

//--- testbench/tmxz_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmxz_consts.vh"
module tmxz_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic meas_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic pulse_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Address phases taken on the bus
    wire tk = hsel_in & htrans_in[1] & hready_in;
    wire rd_tk = tk & ~hwrite_in;
    wire wr_tk = tk & hwrite_in;
    wire [7:0] adr = haddr_in[7:0];
    wire unmapped = (adr > 8'h28) || (adr[1:0] != 2'h0);
    logic wr_pend;
    logic [7:0] wr_adr;
    logic a_w;
    logic b_w;
    logic [2:0] mask_sh;

    // Shadow of mode register writes and of the interrupt mask
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_pend <= 1'b0;
            wr_adr <= 8'h0;
            a_w <= 1'b0;
            b_w <= 1'b0;
            mask_sh <= 3'h0;
        end else begin
            wr_pend <= wr_tk;
            wr_adr <= adr;
            if (wr_tk && adr == `TMXZ_OFF_A_MODE)
                a_w <= 1'b1;
            if (wr_tk && adr == `TMXZ_OFF_B_MODE)
                b_w <= 1'b1;
            if (wr_pend && wr_adr == `TMXZ_OFF_IRQ_MASK)
                mask_sh <= hwdata_in[2:0];
        end
    end

    property p_ready;
        hreadyout_out;
    endproperty
    a_ready: assert property (p_ready) else $error("hreadyout dropped");
    property p_resp;
        !hresp_out;
    endproperty
    a_resp: assert property (p_resp) else $error("hresp not okay");
    property p_rst_out;
        !$past(rst_n_in) |-> !irq_out && !pulse_out;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
    property p_unmapped;
        rd_tk && unmapped |=> hrdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_a_bits;
        rd_tk && adr == `TMXZ_OFF_A_MODE |=> hrdata_out[31:6] == 26'h0;
    endproperty
    a_a_bits: assert property (p_a_bits) else $error("timer a mode spare bits set");
    property p_b_bits;
        rd_tk && adr == `TMXZ_OFF_B_MODE |=> hrdata_out[31:8] == 24'h0 && !hrdata_out[6];
    endproperty
    a_b_bits: assert property (p_b_bits) else $error("timer b mode spare bits set");
    property p_a_stop;
        rd_tk && adr == `TMXZ_OFF_A_MODE && !a_w |=> !hrdata_out[`TMXZ_A_RUN];
    endproperty
    a_a_stop: assert property (p_a_stop) else $error("timer a runs after reset");
    property p_b_stop;
        rd_tk && adr == `TMXZ_OFF_B_MODE && !b_w |=> !hrdata_out[`TMXZ_B_RUN];
    endproperty
    a_b_stop: assert property (p_b_stop) else $error("timer b runs after reset");
    property p_irq_idle;
        !a_w && !b_w |-> !irq_out;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq with both timers stopped");
    property p_irq_mask;
        mask_sh == 3'h0 && $past(mask_sh) == 3'h0 |-> !irq_out;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq with mask clear");
    property p_rd_hold;
        !$past(rd_tk) |-> $stable(hrdata_out);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
endmodule // tmxz_chk
`default_nettype wire

//--- testbench/test_timer_x_z_start_stop_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmxz_consts.vh"
module test_timer_x_z_start_stop_control;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic hwrite_in = 1'b0;
    logic [2:0] hsize_in = 3'h0;
    logic [31:0] hwdata_in = 32'h0;
    logic meas_in = 1'b0;
    wire [31:0] hrdata_out;
    wire hreadyout_out;
    wire hresp_out;
    wire pulse_out;
    wire irq_out;
    integer miscompares;
    integer checks_done;
    integer seed;
    integer i;
    logic [31:0] v;
    logic [31:0] r;

    // Free running bus clock
    always #20 clk_in = ~clk_in;

    tmxz_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .meas_in(meas_in), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .pulse_out(pulse_out),
        .irq_out(irq_out));

    // Comparison with counting
    task automatic chk(input string nm, input [31:0] e, input [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One single AHB transfer, address phase then data phase
    task automatic bus(input logic w, input [7:0] a, input [31:0] d, output [31:0] q);
        @(posedge clk_in);
        hsel_in <= 1'b1;
        haddr_in <= {24'h0, a};
        htrans_in <= 2'h2;
        hwrite_in <= w;
        hsize_in <= 3'h2;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        q = hrdata_out;
    endtask

    task automatic wr(input [7:0] a, input [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string nm, input [7:0] a, input [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    // Poll a run status bit until it shows the written value
    task automatic wait_run(input [7:0] a, input integer b, input logic e);
        logic [31:0] q;
        integer k;
        k = 0;
        bus(1'b0, a, 32'h0, q);
        while (q[b] !== e && k < 40) begin
            bus(1'b0, a, 32'h0, q);
            k = k + 1;
        end
        chk("run status", {31'h0, e}, {31'h0, q[b]});
    endtask

    task automatic close_out;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles of the run
    initial begin
        #2000000;
        miscompares = miscompares + 1;
        close_out;
    end

    // Main sequence
    initial begin
        miscompares = 0;
        checks_done = 0;
        seed = 32'h1a7e4fb9;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        // Reset values, the gap above the map and a misaligned place
        for (i = 0; i < 12; i = i + 1) begin
            v = (i == 1 || i == 2 || i == 5 || i == 6 || i == 7) ? 32'hff : 32'h0;
            rdchk("reset value", i * 4, v);
        end
        rdchk("misaligned", 8'h02, 32'h0);
        // Random register contents while stopped
        for (i = 0; i < 4; i = i + 1) begin
            v = $random(seed);
            wr(`TMXZ_OFF_IRQ_MASK, v);
            rdchk("irq mask", `TMXZ_OFF_IRQ_MASK, {29'h0, v[2:0]});
            wr(`TMXZ_OFF_A_PRE, v);
            rdchk("a prescaler", `TMXZ_OFF_A_PRE, {24'h0, v[7:0]});
        end
        wr(`TMXZ_OFF_IRQ_MASK, 32'h0);
        // Timer A in measurement mode, slow source
        wr(`TMXZ_OFF_SRC, 32'h3);
        wr(`TMXZ_OFF_A_PRE, 32'h40);
        wr(`TMXZ_OFF_A_MODE, 32'h01);
        wr(`TMXZ_OFF_A_MODE, 32'h11);
        wait_run(`TMXZ_OFF_A_MODE, 4, 1'b1);
        repeat (80) @(posedge clk_in);
        bus(1'b0, `TMXZ_OFF_A_PRE, 32'h0, r);
        chk("a counting", 32'h1, {31'h0, r !== 32'h40});
        // Two prescaler periods pass, then the edge flag is cleared
        repeat (4200) @(posedge clk_in);
        rdchk("no early edge flag", `TMXZ_OFF_A_MODE, 32'h11);
        wr(`TMXZ_OFF_A_MODE, 32'h11);
        @(posedge clk_in);
        meas_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rdchk("edge flag set", `TMXZ_OFF_A_MODE, 32'h19);
        wr(`TMXZ_OFF_A_MODE, 32'h39);
        rdchk("flags kept", `TMXZ_OFF_A_MODE, 32'h19);
        wr(`TMXZ_OFF_IRQ_MASK, 32'h2);
        repeat (2) @(posedge clk_in);
        chk("irq raised", 32'h1, {31'h0, irq_out});
        wr(`TMXZ_OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        wr(`TMXZ_OFF_IRQ_MASK, 32'h2);
        wr(`TMXZ_OFF_IRQ_STAT, 32'h2);
        repeat (2) @(posedge clk_in);
        chk("irq cleared", 32'h0, {31'h0, irq_out});
        rdchk("irq status", `TMXZ_OFF_IRQ_STAT, 32'h0);
        wr(`TMXZ_OFF_A_MODE, 32'h31);
        rdchk("edge flag cleared", `TMXZ_OFF_A_MODE, 32'h11);
        wr(`TMXZ_OFF_A_MODE, 32'h01);
        wait_run(`TMXZ_OFF_A_MODE, 4, 1'b0);
        bus(1'b0, `TMXZ_OFF_A_PRE, 32'h0, r);
        repeat (100) @(posedge clk_in);
        rdchk("a stopped", `TMXZ_OFF_A_PRE, r);
        meas_in <= 1'b0;
        // Timer B in both one-shot modes, stopped two ways
        for (i = 2; i < 4; i = i + 1) begin
            // A shot start left from a run stop would restart counting at once
            wr(`TMXZ_OFF_B_OS, 32'h0);
            wr(`TMXZ_OFF_B_MODE, i << 4);
            wr(`TMXZ_OFF_B_PRE, 32'h1);
            wr(`TMXZ_OFF_B_SEC, 32'h1);
            wr(`TMXZ_OFF_B_PRI, 32'h80);
            wr(`TMXZ_OFF_B_MODE, (i << 4) | 32'h80);
            wait_run(`TMXZ_OFF_B_MODE, 7, 1'b1);
            wr(`TMXZ_OFF_B_OS, 32'h1);
            repeat (60) @(posedge clk_in);
            bus(1'b0, `TMXZ_OFF_B_PRI, 32'h0, r);
            chk("b counting", 32'h1, {31'h0, r < 32'h80});
            chk("pulse active", 32'h1, {31'h0, pulse_out});
            wr(`TMXZ_OFF_B_OS, 32'h0);
            rdchk("reload on shot stop", `TMXZ_OFF_B_PRI, 32'h80);
            chk("pulse idle", 32'h0, {31'h0, pulse_out});
            // Second shot with the output inverted
            wr(`TMXZ_OFF_B_OS, 32'h3);
            repeat (60) @(posedge clk_in);
            chk("pulse inverted", 32'h0, {31'h0, pulse_out});
            wr(`TMXZ_OFF_B_MODE, i << 4);
            wait_run(`TMXZ_OFF_B_MODE, 7, 1'b0);
            rdchk("reload on run stop", `TMXZ_OFF_B_PRI, 32'h80);
        end
        // Free-running timer B and a fast timer A underflow
        wr(`TMXZ_OFF_B_OS, 32'h0);
        wr(`TMXZ_OFF_B_MODE, 32'h0);
        wr(`TMXZ_OFF_B_PRE, 32'h0);
        wr(`TMXZ_OFF_B_PRI, 32'h1);
        wr(`TMXZ_OFF_A_PRE, 32'h0);
        wr(`TMXZ_OFF_A_CNT, 32'h0);
        wr(`TMXZ_OFF_SRC, 32'h0);
        wr(`TMXZ_OFF_IRQ_STAT, 32'h7);
        rdchk("irq status idle", `TMXZ_OFF_IRQ_STAT, 32'h0);
        wr(`TMXZ_OFF_B_MODE, 32'h80);
        wait_run(`TMXZ_OFF_B_MODE, 7, 1'b1);
        wr(`TMXZ_OFF_A_MODE, 32'h11);
        wait_run(`TMXZ_OFF_A_MODE, 4, 1'b1);
        rdchk("underflow flag", `TMXZ_OFF_A_MODE, 32'h31);
        rdchk("both underflows", `TMXZ_OFF_IRQ_STAT, 32'h5);
        // Timer mode output toggles on every second tick here
        @(negedge clk_in);
        r[0] = pulse_out;
        repeat (2) @(negedge clk_in);
        chk("pulse toggles", {31'h0, ~r[0]}, {31'h0, pulse_out});
        close_out;
    end
endmodule // test_timer_x_z_start_stop_control

bind tmxz_top tmxz_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .meas_in(meas_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .pulse_out(pulse_out),
    .irq_out(irq_out));
`default_nettype wire
